//--- core/rsse_exec.sv
// execution unit for rotate right, subtracts, nibble swap and sleep entry
`timescale 1ns/10ps
module rsse_exec
    import rsse_pkg::*;
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic clk_en,
    // instruction
    input wire logic exec_valid,
    input wire logic [2:0] exec_op,
    input wire logic dest_sel,
    input wire logic [7:0] file_in,
    input wire logic [7:0] literal_in,
    // flags from the status register
    input wire logic carry_in,
    // results
    output logic [7:0] acc,
    output logic [7:0] file_out,
    output logic file_we,
    output logic carry,
    output logic nibble_borrow_inverse_flag,
    output logic zero,
    output logic timeout_status_bit,
    output logic power_down_status_bit,
    output logic [7:0] watchdog_counter,
    output logic [7:0] watchdog_prescaler,
    output logic watchdog_clear
);
    rsse_op_t op;
    logic [7:0] next_result;
    logic [8:0] diff;
    logic [4:0] ndiff;
    logic [7:0] minuend;
    logic borrow_in;
    logic is_sub;
    logic has_dest;

    assign op = rsse_op_t'(exec_op);

    always_comb begin
        minuend = (op == subtract_acc_from_literal_op) ? literal_in : file_in;
        borrow_in = (op == subtract_with_borrow_op) ? ~carry_in : 1'b0;
        diff = {1'b0, minuend} - {1'b0, acc} - {8'h00, borrow_in};
        ndiff = {1'b0, minuend[3:0]} - {1'b0, acc[3:0]} - {4'h0, borrow_in};
        is_sub = (op == subtract_acc_from_file_op) || (op == subtract_acc_from_literal_op)
            || (op == subtract_with_borrow_op);
        has_dest = is_sub && (op != subtract_acc_from_literal_op)
            || (op == rotate_right_through_flag_op) || (op == nibble_exchange_op);
        case (op)
            rotate_right_through_flag_op: next_result = {carry_in, file_in[7:1]};
            nibble_exchange_op: next_result = {file_in[3:0], file_in[7:4]};
            default: next_result = diff[7:0];
        endcase
    end

    // destination steering
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            acc <= ACC_RESET;
            file_out <= 8'h00;
            file_we <= 1'b0;
        end else if (clk_en) begin
            file_we <= 1'b0;
            if (exec_valid && op == subtract_acc_from_literal_op) begin
                acc <= next_result;
            end else if (exec_valid && has_dest) begin
                if (dest_sel == DEST_ACC) begin
                    acc <= next_result;
                end else begin
                    file_out <= next_result;
                    file_we <= 1'b1;
                end
            end
        end
    end

    // arithmetic flags
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            carry <= 1'b0;
            nibble_borrow_inverse_flag <= 1'b0;
            zero <= 1'b0;
        end else if (clk_en) begin
            if (exec_valid && op == rotate_right_through_flag_op) begin
                carry <= file_in[0];
            end else if (exec_valid && is_sub) begin
                carry <= ~diff[8];
                nibble_borrow_inverse_flag <= ~ndiff[4];
                zero <= (diff[7:0] == 8'h00);
            end else begin
                carry <= carry_in;
            end
        end
    end

    // sleep entry
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            timeout_status_bit <= TIMEOUT_RESET;
            power_down_status_bit <= PWRDN_RESET;
            watchdog_counter <= WCNT_CLEAR;
            watchdog_prescaler <= PRE_CLEAR;
            watchdog_clear <= 1'b0;
        end else if (clk_en) begin
            watchdog_clear <= exec_valid && op == rsse_sleep_op;
            if (exec_valid && op == rsse_sleep_op) begin
                watchdog_counter <= WCNT_CLEAR;
                watchdog_prescaler <= PRE_CLEAR;
                timeout_status_bit <= 1'b1;
                power_down_status_bit <= 1'b0;
            end else begin
                watchdog_counter <= watchdog_counter + 8'h01;
                watchdog_prescaler <= watchdog_prescaler + 8'h01;
            end
        end
    end

    // checks: rotate
    rotate_carry_a: assert property (
        @(posedge ref_clk) disable iff (!arst_n)
        clk_en && exec_valid && op == rotate_right_through_flag_op
        |=> carry == $past(file_in[0]))
        else $error("rotate carry wrong");
    rotate_result_a: assert property (
        @(posedge ref_clk) disable iff (!arst_n)
        clk_en && exec_valid && op == rotate_right_through_flag_op && !dest_sel
        |=> acc == {$past(carry_in), $past(file_in[7:1])})
        else $error("rotate result wrong");
    rotate_file_a: assert property (
        @(posedge ref_clk) disable iff (!arst_n)
        clk_en && exec_valid && op == rotate_right_through_flag_op && dest_sel
        |=> file_out == {$past(carry_in), $past(file_in[7:1])})
        else $error("rotate file result wrong");
    rotate_flags_a: assert property (
        @(posedge ref_clk) disable iff (!arst_n)
        clk_en && exec_valid && op == rotate_right_through_flag_op
        |=> $stable(zero) && $stable(nibble_borrow_inverse_flag))
        else $error("rotate touched a flag");

    // checks: destination steering
    dest_file_a: assert property (
        @(posedge ref_clk) disable iff (!arst_n)
        clk_en && exec_valid && has_dest && dest_sel
        |=> file_we && $stable(acc))
        else $error("file destination not written");
    dest_acc_a: assert property (
        @(posedge ref_clk) disable iff (!arst_n)
        clk_en && exec_valid && has_dest && !dest_sel
        |=> !file_we && $stable(file_out))
        else $error("accumulator destination wrote file");

    // checks: sleep entry
    watchdog_cleared_a: assert property (
        @(posedge ref_clk) disable iff (!arst_n)
        clk_en && exec_valid && op == rsse_sleep_op
        |=> watchdog_counter == WCNT_CLEAR && watchdog_prescaler == PRE_CLEAR)
        else $error("watchdog not cleared");
    sleep_pulse_a: assert property (
        @(posedge ref_clk) disable iff (!arst_n)
        clk_en && exec_valid && op == rsse_sleep_op
        |=> watchdog_clear)
        else $error("watchdog clear pulse missing");
    sleep_status_a: assert property (
        @(posedge ref_clk) disable iff (!arst_n)
        clk_en && exec_valid && op == rsse_sleep_op
        |=> timeout_status_bit && !power_down_status_bit && $stable(zero))
        else $error("sleep status wrong");
    sleep_quiet_a: assert property (
        @(posedge ref_clk) disable iff (!arst_n)
        clk_en && exec_valid && op == rsse_sleep_op
        |=> $stable(acc) && !file_we && $stable(nibble_borrow_inverse_flag))
        else $error("sleep changed other state");

    // checks: file minus accumulator
    sub_carry_a: assert property (
        @(posedge ref_clk) disable iff (!arst_n)
        clk_en && exec_valid && op == subtract_acc_from_file_op
        |=> carry == ($past(acc) <= $past(file_in)))
        else $error("subtract carry wrong");
    sub_nibble_a: assert property (
        @(posedge ref_clk) disable iff (!arst_n)
        clk_en && exec_valid && op == subtract_acc_from_file_op
        |=> nibble_borrow_inverse_flag == ($past(acc[3:0]) <= $past(file_in[3:0])))
        else $error("subtract nibble flag wrong");
    sub_result_a: assert property (
        @(posedge ref_clk) disable iff (!arst_n)
        clk_en && exec_valid && op == subtract_acc_from_file_op && dest_sel
        |=> file_out == 8'($past(file_in) - $past(acc)))
        else $error("subtract result wrong");
    file_zero_a: assert property (
        @(posedge ref_clk) disable iff (!arst_n)
        clk_en && exec_valid && op == subtract_acc_from_file_op
        |=> zero == ($past(file_in) == $past(acc)))
        else $error("subtract zero wrong");

    // checks: literal minus accumulator
    lit_result_a: assert property (
        @(posedge ref_clk) disable iff (!arst_n)
        clk_en && exec_valid && op == subtract_acc_from_literal_op
        |=> acc == 8'($past(literal_in) - $past(acc)))
        else $error("literal subtract wrong");
    lit_flags_a: assert property (
        @(posedge ref_clk) disable iff (!arst_n)
        clk_en && exec_valid && op == subtract_acc_from_literal_op
        |=> carry == ($past(acc) <= $past(literal_in))
        && nibble_borrow_inverse_flag == ($past(acc[3:0]) <= $past(literal_in[3:0])))
        else $error("literal subtract flags wrong");
    lit_no_write_a: assert property (
        @(posedge ref_clk) disable iff (!arst_n)
        clk_en && exec_valid && op == subtract_acc_from_literal_op
        |=> !file_we)
        else $error("literal subtract wrote file");
    lit_zero_a: assert property (
        @(posedge ref_clk) disable iff (!arst_n)
        clk_en && exec_valid && op == subtract_acc_from_literal_op
        |=> zero == ($past(literal_in) == $past(acc)))
        else $error("literal zero wrong");

    // checks: subtract with borrow
    borrow_carry_a: assert property (
        @(posedge ref_clk) disable iff (!arst_n)
        clk_en && exec_valid && op == subtract_with_borrow_op
        |=> carry == ({1'b0, $past(acc)} + {8'h00, ~$past(carry_in)} <= {1'b0, $past(file_in)}))
        else $error("borrow carry wrong");
    borrow_result_a: assert property (
        @(posedge ref_clk) disable iff (!arst_n)
        clk_en && exec_valid && op == subtract_with_borrow_op && dest_sel
        |=> file_out == 8'($past(file_in) - $past(acc) - {7'h00, ~$past(carry_in)}))
        else $error("borrow result wrong");
    sub_zero_a: assert property (
        @(posedge ref_clk) disable iff (!arst_n)
        clk_en && exec_valid && op == subtract_with_borrow_op
        |=> zero == (8'($past(file_in) - $past(acc) - {7'h00, ~$past(carry_in)}) == 8'h00))
        else $error("zero flag wrong");

    // checks: nibble swap
    swap_result_a: assert property (
        @(posedge ref_clk) disable iff (!arst_n)
        clk_en && exec_valid && op == nibble_exchange_op && dest_sel
        |=> file_out == {$past(file_in[3:0]), $past(file_in[7:4])} && $stable(zero))
        else $error("swap wrong");
    swap_acc_a: assert property (
        @(posedge ref_clk) disable iff (!arst_n)
        clk_en && exec_valid && op == nibble_exchange_op && !dest_sel
        |=> acc == {$past(file_in[3:0]), $past(file_in[7:4])}
        && $stable(nibble_borrow_inverse_flag))
        else $error("swap to accumulator wrong");

    // checks: clock enable low holds acc, file_we, carry, zero, watchdog_counter and the time-out bit
    frozen_state_a: assert property (
        @(posedge ref_clk) disable iff (!arst_n)
        !clk_en
        |=> $stable(acc) && $stable(file_we) && $stable(carry) && $stable(zero)
        && $stable(watchdog_counter) && $stable(timeout_status_bit))
        else $error("state moved while frozen");
endmodule

//--- shared/rsse_pkg.sv
// constants for the rotate, subtract, swap and sleep execution unit
// Function
// - rotate right shifts right, old carry into bit 7 and bit 0 into carry, no other flag.
// - destination bit 0 sends the result to the accumulator, 1 back to the file register.
// - the sleep instruction clears the watchdog counter and its prescaler.
// - sleep clears the power-down bit and sets the time-out bit, other status unchanged.
// - file minus accumulator clears carry if the accumulator is larger; digit carry alike.
// - literal minus accumulator goes to the accumulator, flags as for the file subtract.
// - borrow subtract takes file minus accumulator minus inverted carry, updating all flags.
// - nibble swap puts the low nibble of the file operand into the high nibble of the result.
package rsse_pkg;
    localparam int DATA_W = 8;
    localparam int NIB_W = 4;
    localparam int WCNT_W = 8;
    localparam int PRE_W = 8;
    localparam logic [7:0] ACC_RESET = 8'h00;
    localparam logic [7:0] WCNT_CLEAR = 8'h00;
    localparam logic [7:0] PRE_CLEAR = 8'h00;
    localparam logic DEST_ACC = 1'b0;
    localparam logic DEST_FILE = 1'b1;
    localparam logic TIMEOUT_RESET = 1'b1;
    localparam logic PWRDN_RESET = 1'b1;
    typedef enum logic [2:0] {
        rsse_nop_op,
        rotate_right_through_flag_op,
        subtract_acc_from_file_op,
        subtract_acc_from_literal_op,
        subtract_with_borrow_op,
        nibble_exchange_op,
        rsse_sleep_op
    } rsse_op_t;
endpackage

//--- tb/rsse_exec_tb.sv
// self-checking random bench for the rotate, subtract, swap and sleep unit
`timescale 1ns/10ps
module rsse_exec_tb;
    import rsse_pkg::*;
    logic ref_clk = 0, arst_n = 0, clk_en = 0, exec_valid = 0, dest_sel = 0, carry_in = 0;
    logic [2:0] exec_op = 3'h0;
    logic [7:0] file_in = 8'h00, literal_in = 8'h00;
    logic [7:0] acc, file_out, watchdog_counter, watchdog_prescaler, e_acc, e_fo, e_wd, r, rr, a;
    logic file_we, carry, nibble_borrow_inverse_flag, zero, timeout_status_bit;
    logic power_down_status_bit, watchdog_clear, e_we, e_c, e_nbf, e_z, e_to, e_pd, e_wc, nb;
    int n_errors = 0, total_checks = 0, cyc = 0;
    rsse_exec u_rsse_exec (.ref_clk(ref_clk), .arst_n(arst_n), .clk_en(clk_en),
        .exec_valid(exec_valid), .exec_op(exec_op), .dest_sel(dest_sel), .file_in(file_in),
        .literal_in(literal_in), .carry_in(carry_in), .acc(acc), .file_out(file_out),
        .file_we(file_we), .carry(carry), .nibble_borrow_inverse_flag(nibble_borrow_inverse_flag),
        .zero(zero), .timeout_status_bit(timeout_status_bit),
        .power_down_status_bit(power_down_status_bit), .watchdog_counter(watchdog_counter),
        .watchdog_prescaler(watchdog_prescaler), .watchdog_clear(watchdog_clear));
    initial forever #4 ref_clk = ~ref_clk;
    // reference model of the expected register state
    always_comb begin
        a = (exec_op == 3'h3) ? literal_in : file_in;
        nb = (exec_op == 3'h4) & ~carry_in;
        r = a - e_acc - 8'(nb);
        rr = (exec_op == 3'h1) ? {carry_in, file_in[7:1]} :
             (exec_op == 3'h5) ? {file_in[3:0], file_in[7:4]} : r;
    end
    always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            {e_acc, e_fo, e_wd, e_we, e_c, e_nbf, e_z, e_wc} <= '0;
            {e_to, e_pd} <= 2'h3;
        end else if (clk_en) begin
            {e_we, e_wc} <= 2'h0;
            e_c <= carry_in;
            e_wd <= e_wd + 8'h01;
            if (exec_valid && exec_op inside {[3'h1:3'h5]}) begin
                if (dest_sel && exec_op != 3'h3) begin
                    e_fo <= rr;
                    e_we <= 1'b1;
                end else e_acc <= rr;
                if (exec_op < 3'h5) begin
                    e_c <= (exec_op == 3'h1) ? file_in[0] : ({1'b0, a} >= {1'b0, e_acc} + 9'(nb));
                end
                if (exec_op > 3'h1 && exec_op < 3'h5) begin
                    e_nbf <= {1'b0, a[3:0]} >= {1'b0, e_acc[3:0]} + 5'(nb);
                    e_z <= (r == 8'h00);
                end
            end
            if (exec_valid && exec_op == 3'h6) begin
                {e_wd, e_wc, e_to, e_pd} <= {8'h00, 3'h6};
            end
        end
    end
    task chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch t=%0t seen=%h expected=%h", $time, got, exp);
        end
    endtask
    task end_sim();
        $display("errors=%0d checks=%0d", n_errors, total_checks);
        if (n_errors == 0 && total_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    always @(negedge ref_clk) if (arst_n) begin
        chk(acc, e_acc);
        chk(8'(file_we), 8'(e_we));
        if (e_we) chk(file_out, e_fo);
        chk(8'(carry), 8'(e_c));
        chk(8'(nibble_borrow_inverse_flag), 8'(e_nbf));
        chk(8'(zero), 8'(e_z));
        chk(8'({timeout_status_bit, power_down_status_bit}), 8'({e_to, e_pd}));
        chk(watchdog_counter, e_wd);
        chk(watchdog_prescaler, e_wd);
        chk(8'(watchdog_clear), 8'(e_wc));
    end
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc >= 5000) begin
            n_errors++;
            end_sim();
        end
    end
    task drv(input logic [2:0] op, input logic d, input logic [7:0] f, l, input logic c, en, v);
        @(posedge ref_clk);
        {exec_op, dest_sel, file_in, literal_in, carry_in, clk_en} <= {op, d, f, l, c, en};
        exec_valid <= v;
    endtask
    initial begin
        void'($urandom(80));
        repeat (4) @(posedge ref_clk);
        arst_n <= 1'b1;
        // corner cases: walk example, zero result, borrow wrap, frozen sleep
        drv(3'h5, 0, 8'h30, 8'h00, 0, 1, 1);
        drv(3'h2, 1, 8'h05, 8'h00, 0, 1, 1);
        drv(3'h3, 0, 8'h00, 8'h03, 0, 1, 1);
        drv(3'h4, 0, 8'h00, 8'h00, 0, 1, 1);
        drv(3'h1, 1, 8'h81, 8'h00, 1, 1, 1);
        drv(3'h6, 0, 8'h00, 8'h00, 0, 1, 1);
        drv(3'h6, 1, 8'h00, 8'h00, 0, 1, 1);
        drv(3'h3, 1, 8'h00, 8'h10, 0, 1, 1);
        drv(3'h6, 0, 8'h00, 8'h00, 0, 0, 1);
        repeat (3000) begin
            drv(3'($urandom % 7), 1'($urandom), 8'($urandom), 8'($urandom), 1'($urandom),
                ($urandom % 8) != 0, ($urandom % 4) != 0);
        end
        @(posedge ref_clk);
        repeat (2) @(negedge ref_clk);
        end_sim();
    end
endmodule
